/* usrc_pkg.sv */
// constants and types shared by the serial control block
`default_nettype none
package usrc_pkg;
	// ------------------------------------------------------------------
	// register map (printed index, byte address is four times it)
	// ------------------------------------------------------------------
	localparam logic [7:0] SCTL_IDX    = 8'h06;
	localparam logic [7:0] STAT_IDX    = 8'h08;
	localparam logic [7:0] MASK_IDX    = 8'h09;
	localparam logic [7:0] SCTL_RESET  = 8'h00;
	localparam logic [7:0] SCTL_WMASK  = 8'hdf;
	localparam int         RX_ON_BIT   = 7;
	localparam int         TX_ON_BIT   = 6;
	localparam int         SFD_ON_BIT  = 4;
	localparam int         OD_BIT      = 3;
	localparam int         RX_MODE_LO  = 1;
	localparam int         MULTI_BIT   = 0;
	// ------------------------------------------------------------------
	// receiver mode codes and baud divisors
	// ------------------------------------------------------------------
	localparam logic [1:0] RXM_NORMAL  = 2'h0;
	localparam logic [1:0] RXM_DOUBLE  = 2'h1;
	localparam logic [1:0] RXM_GEN_AUTO = 2'h2;
	localparam logic [1:0] RXM_BUS_AUTO = 2'h3;
	localparam logic [4:0] DIV_NORMAL  = 5'h10;
	localparam logic [4:0] DIV_DOUBLE  = 5'h08;
	// ------------------------------------------------------------------
	// autobaud measurement
	// ------------------------------------------------------------------
	localparam logic [6:0] LIN_SPAN_MIN = 7'h1a;
	localparam logic [6:0] LIN_SPAN_MAX = 7'h26;
	localparam logic [6:0] GEN_SPAN_MIN = 7'h02;
	localparam logic [6:0] SPAN_CNT_MAX = 7'h7f;
	localparam logic [2:0] SYNC_EDGES   = 3'h5;
	// ------------------------------------------------------------------
	// status and mask bits
	// ------------------------------------------------------------------
	localparam int         ST_W        = 4;
	localparam int         ST_WAKE     = 0;
	localparam int         ST_SYNC_OK  = 1;
	localparam int         ST_SYNC_ERR = 2;
	localparam int         ST_TX_OFF   = 3;
	localparam logic [ST_W-1:0] ST_RESET = 4'h0;

	typedef enum logic [2:0] {
		ABD_IDLE = 3'b001,
		ABD_MEAS = 3'b010,
		ABD_STOP = 3'b100
	} usrc_abd_state_t;

	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction
endpackage : usrc_pkg
`default_nettype wire

/* usrc_abd_if.sv */
// link between the control logic and the autobaud detector
`default_nettype none
interface usrc_abd_if;
	logic       clr;
	logic       gen;
	logic       lin;
	logic       rxd;
	logic       tick;
	logic       ok;
	logic       err;
	logic [7:0] period;
	modport ctl (output clr, gen, lin, rxd, tick, input ok, err, period);
	modport abd (input clr, gen, lin, rxd, tick, output ok, err, period);
endinterface : usrc_abd_if
`default_nettype wire

/* usrc_autobaud.sv */
// autobaud sync-character measurement
`default_nettype none
module usrc_autobaud
	import usrc_pkg::*;
(
	input  wire logic MCLK,
	input  wire logic NRST,
	usrc_abd_if.abd   ab
);
	usrc_abd_state_t st_q, st_d;
	logic [6:0] cnt_q, cnt_d;
	logic [2:0] edg_q, edg_d;
	logic [8:0] sum_q, sum_d;
	logic       prev_q, prev_d, bad_q, bad_d, ok_q, ok_d, err_q, err_d;
	logic [7:0] per_q, per_d;
	logic       fall, span_ok;

	assign fall = prev_q & ~ab.rxd;
	// lin sync spans two bits of 16 samples each, window is nominal plus or minus six
	assign span_ok = ab.lin ? (cnt_q >= LIN_SPAN_MIN && cnt_q <= LIN_SPAN_MAX)
	                        : (cnt_q >= GEN_SPAN_MIN && cnt_q != SPAN_CNT_MAX);
	assign ab.ok = ok_q;
	assign ab.err = err_q;
	assign ab.period = per_q;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		edg_d = edg_q;
		sum_d = sum_q;
		bad_d = bad_q;
		per_d = per_q;
		ok_d = 1'b0;
		err_d = 1'b0;
		prev_d = ab.rxd;
		if (ab.tick && cnt_q != SPAN_CNT_MAX)
			cnt_d = cnt_q + 7'h01;
		case (st_q)
			ABD_IDLE: begin
				if (fall) begin
					st_d = ABD_MEAS;
					// the tick of the edge cycle itself belongs to the new span
					cnt_d = {6'h00, ab.tick};
					edg_d = 3'h1;
					sum_d = 9'h000;
					bad_d = 1'b0;
				end
			end
			ABD_MEAS: begin
				if (fall) begin
					bad_d = bad_q | ~span_ok;
					sum_d = sum_q + {2'b00, cnt_q};
					edg_d = edg_q + 3'h1;
					cnt_d = {6'h00, ab.tick};
					if (edg_q + 3'h1 == SYNC_EDGES)
						st_d = ABD_STOP;
				end
			end
			ABD_STOP: begin
				// sample the stop bit one and a half bits after the last falling edge
				if (cnt_q == sum_q[8:3] + {1'b0, sum_q[8:4]}) begin
					st_d = ABD_IDLE;
					if (bad_q || (ab.lin && !ab.rxd)) begin
						err_d = 1'b1;
					end else begin
						ok_d = 1'b1;
						per_d = {1'b0, sum_q[8:2]} >> 1;
					end
				end
			end
			default: st_d = ABD_IDLE;
		endcase
		if (ab.clr || !(ab.gen || ab.lin)) begin
			st_d = ABD_IDLE;
			cnt_d = 7'h00;
			edg_d = 3'h0;
			bad_d = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			st_q <= ABD_IDLE;
			cnt_q <= 7'h00;
			edg_q <= 3'h0;
			sum_q <= 9'h000;
			prev_q <= 1'b1;
			bad_q <= 1'b0;
			ok_q <= 1'b0;
			err_q <= 1'b0;
			per_q <= 8'h00;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			edg_q <= edg_d;
			sum_q <= sum_d;
			prev_q <= prev_d;
			bad_q <= bad_d;
			ok_q <= ok_d;
			err_q <= err_d;
			per_q <= per_d;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	property p_abd_clr;
		ab.clr |=> st_q == ABD_IDLE && !ok_q;
	endproperty
	a_abd_clr: assert property (p_abd_clr) else $error("autobaud not reset by clear");
	property p_lin_span;
		ab.lin && !ab.clr && st_q == ABD_MEAS && fall && cnt_q > LIN_SPAN_MAX |=> bad_q;
	endproperty
	a_lin_span: assert property (p_lin_span) else $error("long lin span accepted");
	property p_gen_ok;
		ab.gen && !ab.clr && st_q == ABD_STOP && !bad_q
			&& cnt_q == sum_q[8:3] + {1'b0, sum_q[8:4]} |=> ok_q && !err_q;
	endproperty
	a_gen_ok: assert property (p_gen_ok) else $error("valid generic sync refused");
endmodule : usrc_autobaud
`default_nettype wire

/* usrc_ctrl.sv */
// serial control register block with pin control, wake and autobaud
// Summary of operation
// - receiver enable takes over receive pin
// - disabling receiver flushes buffer and error flags
// - disabling receiver resets autobaud detection logic
// - transmitter enable takes over transmit pin
// - transmitter stops only after shifter and buffer empty
// - stopped transmitter releases pin, forces input direction
// - start edge wakes system when detection and receiver enabled
// - open drain mode drives only low
// - double speed divides by 8, not 16
// - synchronous mode ignores speed, mode field zero
// - generic autobaud accepts any valid sync
// - lin autobaud needs spans in window, 0x55
// - mode zero normal speed, one double speed
`default_nettype none
module usrc_ctrl
	import usrc_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        NRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output var  logic        PREADY,
	output var  logic        PSLVERR,
	input  wire logic        RXD_PIN,
	input  wire logic        TX_BIT,
	input  wire logic        TX_SHIFT_BUSY,
	input  wire logic        TX_BUF_EMPTY,
	input  wire logic        SYNC_MODE,
	input  wire logic        BAUD_TICK,
	output var  logic        RX_ENABLE,
	output var  logic        RX_FLUSH,
	output var  logic        TX_ENABLE,
	output var  logic        TXD_O,
	output var  logic        TXD_OE,
	output var  logic        TX_DIR_CLR,
	output var  logic        WAKE,
	output var  logic [4:0]  BAUD_DIV,
	output var  logic        MULTIPROCESSOR_COMM_MODE_EN,
	output var  logic        SYNC_OK,
	output var  logic [7:0]  BAUD_PERIOD,
	output var  logic        IRQ
);
	// ------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------
	logic rxd_m_q, rxd_s_q, rxd_p_q;

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
			rxd_p_q <= 1'b1;
		end else begin
			rxd_m_q <= RXD_PIN;
			rxd_s_q <= rxd_m_q;
			rxd_p_q <= rxd_s_q;
		end
	end

	// ------------------------------------------------------------------
	// apb slave and registers
	// ------------------------------------------------------------------
	logic [7:0]      ctrl_q, ctrl_d;
	logic [ST_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [31:0]     rdata_q, rdata_d;
	logic            rdy_q, rdy_d, err_q, err_d;
	logic            acc, wr, hit_ctrl, hit_stat, hit_mask;
	logic [1:0]      rxm;

	// one wait state lets read data come from a register
	assign acc = PSEL & PENABLE;
	assign wr = acc & rdy_q & PWRITE & ~err_q;
	assign hit_ctrl = PADDR == byte_addr(SCTL_IDX);
	assign hit_stat = PADDR == byte_addr(STAT_IDX);
	assign hit_mask = PADDR == byte_addr(MASK_IDX);
	assign rxm = ctrl_q[RX_MODE_LO +: 2];

	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		rdy_d = acc & ~rdy_q;
		err_d = acc & ~rdy_q & ~(hit_ctrl | hit_stat | hit_mask);
		rdata_d = 32'h0000_0000;
		if (acc && !rdy_q && !PWRITE) begin
			if (hit_ctrl)
				rdata_d = {24'h00_0000, ctrl_q};
			else if (hit_stat)
				rdata_d = {28'h000_0000, stat_q};
			else if (hit_mask)
				rdata_d = {28'h000_0000, mask_q};
		end
		if (wr && hit_ctrl)
			ctrl_d = PWDATA[7:0] & SCTL_WMASK;
		if (wr && hit_mask)
			mask_d = PWDATA[ST_W-1:0];
		// a new event wins over a write-one clear in the same cycle
		stat_d = stat_q;
		if (wr && hit_stat)
			stat_d = stat_q & ~PWDATA[ST_W-1:0];
		stat_d = stat_d | ev;
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= SCTL_RESET;
			stat_q <= ST_RESET;
			mask_q <= ST_RESET;
			rdata_q <= 32'h0000_0000;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
		end
	end

	assign PRDATA = rdata_q;
	assign PREADY = rdy_q;
	assign PSLVERR = err_q;

	// ------------------------------------------------------------------
	// pin control, wake and baud divisor
	// ------------------------------------------------------------------
	logic       receiver_enable_q, receiver_enable_d, flush_q, flush_d, txact_q, txact_d;
	logic       txo_q, txo_d, txoe_q, txoe_d, dclr_q, dclr_d;
	logic       wake_q, wake_d, irq_q, irq_d, multiprocessor_comm_mode_q, multiprocessor_comm_mode_d;
	logic [4:0] div_q, div_d;
	logic       fall;

	usrc_abd_if abd_bus ();

	assign fall = rxd_p_q & ~rxd_s_q;

	always_comb begin
		receiver_enable_d = ctrl_q[RX_ON_BIT];
		flush_d = receiver_enable_q & ~ctrl_q[RX_ON_BIT];
		// transmitter drains shifter and buffer before letting go
		txact_d = ctrl_q[TX_ON_BIT] | (txact_q & (TX_SHIFT_BUSY | ~TX_BUF_EMPTY));
		dclr_d = txact_q & ~txact_d;
		txo_d = 1'b1;
		txoe_d = 1'b0;
		if (txact_q) begin
			if (ctrl_q[OD_BIT]) begin
				txo_d = 1'b0;
				txoe_d = ~TX_BIT;
			end else begin
				txo_d = TX_BIT;
				txoe_d = 1'b1;
			end
		end
		wake_d = ctrl_q[SFD_ON_BIT] & ctrl_q[RX_ON_BIT] & fall;
		if (rxm == RXM_DOUBLE && !SYNC_MODE)
			div_d = DIV_DOUBLE;
		else
			div_d = DIV_NORMAL;
		multiprocessor_comm_mode_d = ctrl_q[MULTI_BIT];
		ev = '0;
		ev[ST_WAKE] = wake_d;
		ev[ST_SYNC_OK] = abd_bus.ok;
		ev[ST_SYNC_ERR] = abd_bus.err;
		ev[ST_TX_OFF] = dclr_d;
		irq_d = |(stat_d & mask_q);
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			receiver_enable_q <= 1'b0;
			flush_q <= 1'b0;
			txact_q <= 1'b0;
			dclr_q <= 1'b0;
			txo_q <= 1'b1;
			txoe_q <= 1'b0;
			wake_q <= 1'b0;
			div_q <= DIV_NORMAL;
			multiprocessor_comm_mode_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			receiver_enable_q <= receiver_enable_d;
			flush_q <= flush_d;
			txact_q <= txact_d;
			dclr_q <= dclr_d;
			txo_q <= txo_d;
			txoe_q <= txoe_d;
			wake_q <= wake_d;
			div_q <= div_d;
			multiprocessor_comm_mode_q <= multiprocessor_comm_mode_d;
			irq_q <= irq_d;
		end
	end

	assign RX_ENABLE = receiver_enable_q;
	assign RX_FLUSH = flush_q;
	assign TX_ENABLE = txact_q;
	assign TX_DIR_CLR = dclr_q;
	assign TXD_O = txo_q;
	assign TXD_OE = txoe_q;
	assign WAKE = wake_q;
	assign BAUD_DIV = div_q;
	assign MULTIPROCESSOR_COMM_MODE_EN = multiprocessor_comm_mode_q;
	assign IRQ = irq_q;

	// ------------------------------------------------------------------
	// autobaud detector
	// ------------------------------------------------------------------
	logic       sok_q;
	logic [7:0] per_q;

	// autobaud is meaningless for synchronous links, so hold it idle there
	assign abd_bus.clr = ~ctrl_q[RX_ON_BIT] | SYNC_MODE;
	assign abd_bus.gen = rxm == RXM_GEN_AUTO;
	assign abd_bus.lin = rxm == RXM_BUS_AUTO;
	assign abd_bus.rxd = rxd_s_q;
	assign abd_bus.tick = BAUD_TICK;

	usrc_autobaud u_abd (
		.MCLK (MCLK),
		.NRST (NRST),
		.ab   (abd_bus)
	);

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			sok_q <= 1'b0;
			per_q <= 8'h00;
		end else begin
			sok_q <= abd_bus.ok;
			per_q <= abd_bus.period;
		end
	end

	assign SYNC_OK = sok_q;
	assign BAUD_PERIOD = per_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	sequence s_start_edge;
		ctrl_q[SFD_ON_BIT] && ctrl_q[RX_ON_BIT] && rxd_p_q ##0 !rxd_s_q;
	endsequence
	property p_rx_en;
		ctrl_q[RX_ON_BIT] |=> RX_ENABLE;
	endproperty
	a_rx_en: assert property (p_rx_en) else $error("receiver not enabled");
	property p_flush;
		$fell(ctrl_q[RX_ON_BIT]) |=> RX_FLUSH ##1 !RX_FLUSH;
	endproperty
	a_flush: assert property (p_flush) else $error("no single flush pulse");
	property p_tx_hold;
		TX_ENABLE && TX_SHIFT_BUSY |=> TX_ENABLE;
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmitter stopped early");
	property p_tx_rel;
		$fell(TX_ENABLE) |-> TX_DIR_CLR ##1 !TXD_OE [*2];
	endproperty
	a_tx_rel: assert property (p_tx_rel) else $error("transmit pin not released");
	property p_tx_on;
		ctrl_q[TX_ON_BIT] && !ctrl_q[OD_BIT] && TX_BIT |=> ##1 TXD_OE && TXD_O;
	endproperty
	a_tx_on: assert property (p_tx_on) else $error("transmit pin not driven");
	property p_wake;
		s_start_edge |=> WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("start edge did not wake");
	property p_od;
		TX_ENABLE && ctrl_q[OD_BIT] |=> !TXD_O && (TXD_OE == !$past(TX_BIT));
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high");
	property p_div;
		!SYNC_MODE && rxm == RXM_DOUBLE |=> BAUD_DIV == DIV_DOUBLE;
	endproperty
	a_div: assert property (p_div) else $error("double speed divisor wrong");
	property p_sync_div;
		SYNC_MODE |=> BAUD_DIV == DIV_NORMAL;
	endproperty
	a_sync_div: assert property (p_sync_div) else $error("sync mode divisor changed");
	property p_rsvd;
		PREADY |-> !PRDATA[5];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
endmodule : usrc_ctrl
`default_nettype wire

/* usrc_node.sv */
// remote serial node model: drives the receive line, watches the transmit line
`default_nettype none
module usrc_node (
	input  wire logic MCLK,
	input  wire logic TXD_O,
	input  wire logic TXD_OE,
	output var  logic RXD,
	output wire logic TXD_LINE
);
	timeunit 1ns;
	timeprecision 1ns;
	// released line floats up through the pull-up
	assign TXD_LINE = TXD_OE ? TXD_O : 1'b1;
	initial RXD = 1'b1;
	// one frame, lsb first; bt is the bit time in clock cycles
	task automatic send(input logic [7:0] b, input int bt);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge MCLK);
			RXD <= f[i];
			repeat (bt - 1) @(posedge MCLK);
		end
	endtask
	task automatic drive(input logic v);
		@(posedge MCLK);
		RXD <= v;
	endtask
endmodule // usrc_node
`default_nettype wire

/* usart_rx_tx_control_bench.sv */
// self-checking bench for the serial control block
`default_nettype none
module usart_rx_tx_control_bench
	import usrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] SCB_IDX = 8'h06;
	localparam logic [7:0] A_CTL   = {SCB_IDX[5:0], 2'b00};
	localparam logic [7:0] A_ST    = {STAT_IDX[5:0], 2'b00};
	localparam logic [7:0] A_MK    = {MASK_IDX[5:0], 2'b00};
	logic        mclk = 1'b0;
	logic        nrst, psel, penable, pwrite, tx_bit, tx_busy, tx_empty, sync_mode, tick;
	logic [7:0]  paddr, period;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, se, rx_en, rx_flush, tx_en, txd_o, txd_oe;
	logic        dir_clr, wake, multiprocessor_comm_mode, sync_ok, irq;
	logic [4:0]  div;
	wire logic   rxd, txd_line;
	int          err_total, comparisons, n_flush, n_wake, n_sync, n_dir, k;

	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		tick <= nrst;
		if (rx_flush === 1'b1) n_flush++;
		if (wake === 1'b1) n_wake++;
		if (sync_ok === 1'b1) n_sync++;
		if (dir_clr === 1'b1) n_dir++;
	end

	usrc_ctrl uut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RXD_PIN(rxd), .TX_BIT(tx_bit),
		.TX_SHIFT_BUSY(tx_busy), .TX_BUF_EMPTY(tx_empty), .SYNC_MODE(sync_mode),
		.BAUD_TICK(tick), .RX_ENABLE(rx_en), .RX_FLUSH(rx_flush), .TX_ENABLE(tx_en),
		.TXD_O(txd_o), .TXD_OE(txd_oe), .TX_DIR_CLR(dir_clr), .WAKE(wake),
		.BAUD_DIV(div), .MULTIPROCESSOR_COMM_MODE_EN(multiprocessor_comm_mode), .SYNC_OK(sync_ok), .BAUD_PERIOD(period),
		.IRQ(irq));
	usrc_node node (.MCLK(mclk), .TXD_O(txd_o), .TXD_OE(txd_oe), .RXD(rxd),
		.TXD_LINE(txd_line));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request held until pready is sampled high; data taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		print_verdict();
	end
	initial begin
		{nrst, psel, penable, pwrite, tick, tx_busy, sync_mode} = 7'h0;
		{tx_bit, tx_empty} = 2'h3;
		paddr = 8'h0;
		pwdata = 32'h0;
		{err_total, comparisons, n_flush, n_wake, n_sync, n_dir} = '0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		cyc(1);
		chk("baud_div", div, 32'h10);
		chk("txd_oe", txd_oe, 32'h0);
		rdchk(A_CTL, 32'h0, "ctl_reset");
		rdchk(A_MK, 32'h0, "mask_reset");
		wr(A_CTL, 32'hff);
		rdchk(A_CTL, 32'hdf, "ctl_rw");
		chk("rx_enable", rx_en, 32'h1);
		chk("tx_enable", tx_en, 32'h1);
		chk("multiprocessor_comm_mode", multiprocessor_comm_mode, 32'h1);
		chk("od_oe_high", txd_oe, 32'h0);
		tx_bit <= 1'b0;
		cyc(3);
		chk("od_line_low", txd_line, 32'h0);
		wr(A_CTL, 32'hc0);
		cyc(3);
		chk("pp_oe", txd_oe, 32'h1);
		chk("pp_o", txd_o, 32'h0);
		tx_bit <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 2; m++) begin
				sync_mode <= s[0];
				wr(A_CTL, 32'h80 | (m << 1));
				cyc(2);
				chk("baud_div", div, (m == 1 && s == 0) ? 32'h8 : 32'h10);
			end
		end
		sync_mode <= 1'b0;
		wr(8'h3c, 32'hff);
		chk("slverr", se, 32'h1);
		rdchk(8'h3c, 32'h0, "unmapped_rd");
		rdchk(A_CTL, 32'h82, "ctl_kept");
		wr(A_CTL, 32'h0);
		cyc(3);
		chk("rx_flush", n_flush, 32'h1);
		chk("rx_enable", rx_en, 32'h0);
		// transmitter drain: busy shifter then non-empty buffer hold it on
		wr(A_MK, 32'h8);
		wr(A_CTL, 32'h40);
		wr(A_ST, 32'hf);
		cyc(1);
		chk("irq_clear", irq, 32'h0);
		tx_busy <= 1'b1;
		tx_empty <= 1'b0;
		k = n_dir;
		wr(A_CTL, 32'h0);
		cyc(10);
		chk("tx_drain", tx_en, 32'h1);
		chk("dir_clr", n_dir, k);
		tx_busy <= 1'b0;
		cyc(4);
		chk("tx_drain", tx_en, 32'h1);
		tx_empty <= 1'b1;
		cyc(4);
		chk("tx_stop", tx_en, 32'h0);
		chk("tx_release", txd_oe, 32'h0);
		chk("dir_clr", n_dir, k + 1);
		chk("irq_tx", irq, 32'h1);
		rdchk(A_ST, 32'h8, "st_tx");
		wr(A_ST, 32'h8);
		cyc(1);
		chk("irq_w1c", irq, 32'h0);
		// start-edge wake, masked in then masked out, then detection off
		wr(A_MK, 32'h1);
		wr(A_CTL, 32'h90);
		for (int i = 0; i < 3; i++) begin
			if (i == 1) wr(A_MK, 32'h0);
			if (i == 2) wr(A_CTL, 32'h80);
			node.drive(1'b0);
			cyc(6);
			chk("wake", n_wake, (i == 2) ? 32'h2 : i + 1);
			chk("irq_wake", irq, (i == 0) ? 32'h1 : 32'h0);
			rdchk(A_ST, (i == 2) ? 32'h0 : 32'h1, "st_wake");
			wr(A_ST, 32'h1);
			node.drive(1'b1);
		end
		// autobaud: bus-protocol mode accepts 32 samples per span, not 48
		wr(A_ST, 32'hf);
		wr(A_CTL, 32'h86);
		node.send(8'h55, 16);
		cyc(40);
		chk("lin_sync", n_sync, 32'h1);
		chk("lin_period", period, 32'h10);
		node.send(8'h55, 24);
		cyc(40);
		chk("lin_reject", n_sync, 32'h1);
		rdchk(A_ST, 32'h6, "st_sync");
		wr(A_CTL, 32'h0);
		wr(A_CTL, 32'h84);
		node.send(8'h55, 24);
		cyc(40);
		chk("gen_sync", n_sync, 32'h2);
		chk("gen_period", period, 32'h18);
		print_verdict();
	end
endmodule // usart_rx_tx_control_bench
`default_nettype wire
